//--- rtl/rps_delay_counter.sv
// down counter that times start-up and wake delays
// assumes load_i is a single-cycle strobe from the sequencer
`timescale 1ns/1ns
module rps_delay_counter
  import rps_pkg::*;
#(
  parameter int W = 22
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  output logic done_o
);

  logic [W-1:0] count_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_ff <= '0;
    else if (ce_i)
    begin
      if (load_i)
        count_ff <= value_i;
      else if (count_ff != '0)
        count_ff <= count_ff - W'(1);
    end
  end

  assign done_o = (count_ff == '0);

endmodule : rps_delay_counter

//--- rtl/rps_pkg.sv
// types shared by the power sequencer and its delay counter
// assumes rps_regs.svh for register and timing constants; the state codes are set here
package rps_pkg;

  typedef enum logic [5:0] {
    RPS_ST_POR   = 6'h01,
    RPS_ST_START = 6'h02,
    RPS_ST_RUN   = 6'h04,
    RPS_ST_SLEEP = 6'h08,
    RPS_ST_WAKE  = 6'h10,
    RPS_ST_BROWN = 6'h20
  } rps_state_e;

  typedef logic [31:0] rps_word_t;

endpackage : rps_pkg

//--- rtl/rps_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 50 MHz clock and a 32-bit classic Wishbone slave port
`ifndef RPS_REGS_SVH
`define RPS_REGS_SVH

`define RPS_CLK_MHZ 50
`define RPS_SETTLE_TIME_NS 10000
`define RPS_SETTLE_CYCLES ((`RPS_SETTLE_TIME_NS * `RPS_CLK_MHZ + 999) / 1000)
`define RPS_POWER_UP_TIME_MS 64
`define RPS_POWER_UP_CYCLES (`RPS_POWER_UP_TIME_MS * `RPS_CLK_MHZ * 1000)
`define RPS_CNT_W 22

`define RPS_ADR_RESET_CTRL 8'h00
`define RPS_ADR_INT_FLAG 8'h04
`define RPS_ADR_INT_MASK 8'h08
`define RPS_ADR_STATUS 8'h0C

`define RPS_BIT_KEEP_POWERED 8
`define RPS_BIT_BROWN_OUT 1
`define RPS_BIT_LV_FLAG 8
`define RPS_BIT_BROWN_EVT 1
`define RPS_BIT_READY_EVT 0
`define RPS_INT_BITS 32'h0000_0103

`define RPS_RST_RESET_CTRL 32'h0000_0000
`define RPS_RST_INT_FLAG 32'h0000_0000
`define RPS_RST_INT_MASK 32'h0000_0000

`endif

//--- rtl/rps_sequencer.sv
// regulator start-up, sleep standby and brown-out sequencer
// assumes pins strap/comparators are asynchronous, sleep/wake requests
// come from core logic on clk_i, registers over classic Wishbone
`timescale 1ns/1ns
`include "rps_regs.svh"
module rps_sequencer
  import rps_pkg::*;
#(
  parameter int POWER_UP_CYCLES = `RPS_POWER_UP_CYCLES,
  parameter int SETTLE_CYCLES = `RPS_SETTLE_CYCLES
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic regulator_enable_strap_i,
  input wire logic low_voltage_cmp_i,
  input wire logic brown_out_cmp_i,
  input wire logic sleep_req_i,
  input wire logic wake_req_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic exec_enable_o,
  output logic regulator_standby_o,
  output logic flash_power_o,
  output logic brown_out_reset_o,
  output logic irq_o
);

  localparam int CW = `RPS_CNT_W;
  localparam int NSYNC = 3;

  // pin synchronisers: strap, low-voltage comparator, brown-out comparator
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic [NSYNC-1:0] pin_async;
  logic strap;
  logic lv_cmp;
  logic bo_cmp;
  logic lv_prev_ff;
  logic [1:0] sync_fill_ff;

  assign pin_async = {brown_out_cmp_i, low_voltage_cmp_i, regulator_enable_strap_i};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
        end
        else if (ce_i)
        begin
          sync1_ff[gi] <= pin_async[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  assign strap = sync2_ff[0];
  assign lv_cmp = sync2_ff[1];
  assign bo_cmp = sync2_ff[2];

  // synchronised strap is only trusted once both stages have filled
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sync_fill_ff <= 2'h0;
    else if (ce_i)
      sync_fill_ff <= {sync_fill_ff[0], 1'b1};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lv_prev_ff <= 1'b0;
    else if (ce_i)
      lv_prev_ff <= lv_cmp;
  end

  // registers and wishbone decode
  logic keep_powered_ff;
  logic brown_flag_ff;
  rps_word_t int_flag_ff;
  rps_word_t int_mask_ff;
  logic ack_ff;
  rps_word_t dat_ff;
  logic wb_req;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_flag;

  assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr_ctrl = wb_req && wb_we_i && (wb_adr_i == `RPS_ADR_RESET_CTRL);
  assign wr_mask = wb_req && wb_we_i && (wb_adr_i == `RPS_ADR_INT_MASK);
  assign rd_flag = wb_req && !wb_we_i && (wb_adr_i == `RPS_ADR_INT_FLAG);

  // sequencer state
  rps_state_e state_ff;
  rps_state_e nxt_state;
  logic cnt_load;
  logic [CW-1:0] cnt_value;
  logic cnt_done;
  logic brown_event;
  logic lv_event;
  logic ready_event;
  logic [CW-1:0] settle_val;
  logic [CW-1:0] power_up_val;
  logic [CW-1:0] start_val;

  assign settle_val = CW'(SETTLE_CYCLES);
  assign power_up_val = CW'(POWER_UP_CYCLES);
  assign start_val = strap ? settle_val : power_up_val;
  // a brown-out only exists on the regulator path
  assign brown_event = strap && bo_cmp && (state_ff != RPS_ST_BROWN) && (state_ff != RPS_ST_POR);
  assign lv_event = strap && lv_cmp && !lv_prev_ff;

  rps_delay_counter #(
    .W(CW)
  ) u_delay (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .load_i(cnt_load),
    .value_i(cnt_value),
    .done_o(cnt_done)
  );

  always_comb
  begin
    nxt_state = state_ff;
    cnt_load = 1'b0;
    cnt_value = start_val;
    unique case (state_ff)
      RPS_ST_POR:
      begin
        if (sync_fill_ff[1])
        begin
          nxt_state = RPS_ST_START;
          cnt_load = 1'b1;
        end
      end
      RPS_ST_START:
      begin
        if (brown_event)
          nxt_state = RPS_ST_BROWN;
        else if (cnt_done)
          nxt_state = RPS_ST_RUN;
      end
      RPS_ST_RUN:
      begin
        if (brown_event)
          nxt_state = RPS_ST_BROWN;
        else if (sleep_req_i)
          nxt_state = RPS_ST_SLEEP;
      end
      RPS_ST_SLEEP:
      begin
        if (brown_event)
          nxt_state = RPS_ST_BROWN;
        else if (wake_req_i)
        begin
          if (keep_powered_ff)
            nxt_state = RPS_ST_RUN;
          else
          begin
            nxt_state = RPS_ST_WAKE;
            cnt_load = 1'b1;
            cnt_value = settle_val;
          end
        end
      end
      RPS_ST_WAKE:
      begin
        if (brown_event)
          nxt_state = RPS_ST_BROWN;
        else if (cnt_done)
          nxt_state = RPS_ST_RUN;
      end
      RPS_ST_BROWN:
      begin
        // restart with a full start-up delay once the supply recovers
        if (!bo_cmp)
        begin
          nxt_state = RPS_ST_START;
          cnt_load = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_ff <= RPS_ST_POR;
    else if (ce_i)
      state_ff <= nxt_state;
  end

  // outputs come straight from flops, derived from the next state
  logic exec_ff;
  logic standby_ff;
  logic flash_pwr_ff;
  logic brown_rst_ff;
  logic nxt_exec;

  assign nxt_exec = (nxt_state == RPS_ST_RUN);
  assign ready_event = nxt_exec && !exec_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      exec_ff <= 1'b0;
    else if (ce_i)
      exec_ff <= nxt_exec;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      standby_ff <= 1'b0;
      flash_pwr_ff <= 1'b1;
    end
    else if (ce_i)
    begin
      standby_ff <= (nxt_state == RPS_ST_SLEEP) && strap && !keep_powered_ff;
      flash_pwr_ff <= !((nxt_state == RPS_ST_SLEEP) && !keep_powered_ff);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      brown_rst_ff <= 1'b0;
    else if (ce_i)
      brown_rst_ff <= (nxt_state == RPS_ST_BROWN);
  end

  // reset control word: keep-powered bit and brown-out flag
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      keep_powered_ff <= 1'(`RPS_RST_RESET_CTRL >> `RPS_BIT_KEEP_POWERED);
    else if (ce_i && wr_ctrl && wb_sel_i[1])
      keep_powered_ff <= wb_dat_i[`RPS_BIT_KEEP_POWERED];
  end

  // hardware set beats a software clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      brown_flag_ff <= 1'b0;
    else if (ce_i)
    begin
      if (brown_event)
        brown_flag_ff <= 1'b1;
      else if (wr_ctrl && wb_sel_i[0])
        brown_flag_ff <= wb_dat_i[`RPS_BIT_BROWN_OUT];
    end
  end

  // interrupt flags: sticky, cleared by reading them
  rps_word_t flag_set;
  rps_word_t nxt_int_flag;

  always_comb
  begin
    flag_set = '0;
    flag_set[`RPS_BIT_LV_FLAG] = lv_event;
    flag_set[`RPS_BIT_BROWN_EVT] = brown_event;
    flag_set[`RPS_BIT_READY_EVT] = ready_event;
    nxt_int_flag = rd_flag ? flag_set : (int_flag_ff | flag_set);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      int_flag_ff <= `RPS_RST_INT_FLAG;
    else if (ce_i)
      int_flag_ff <= nxt_int_flag;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      int_mask_ff <= `RPS_RST_INT_MASK;
    else if (ce_i && wr_mask)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (wb_sel_i[b])
          int_mask_ff[b*8 +: 8] <= wb_dat_i[b*8 +: 8] & 8'(`RPS_INT_BITS >> (b*8));
      end
    end
  end

  logic irq_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_ff <= 1'b0;
    else if (ce_i)
      irq_ff <= |(nxt_int_flag & int_mask_ff);
  end

  // wishbone read data and ack; unmapped addresses read zero and ack
  rps_word_t rd_mux;

  always_comb
  begin
    rd_mux = '0;
    unique case (wb_adr_i)
      `RPS_ADR_RESET_CTRL:
      begin
        rd_mux[`RPS_BIT_KEEP_POWERED] = keep_powered_ff;
        rd_mux[`RPS_BIT_BROWN_OUT] = brown_flag_ff;
      end
      `RPS_ADR_INT_FLAG: rd_mux = int_flag_ff;
      `RPS_ADR_INT_MASK: rd_mux = int_mask_ff;
      `RPS_ADR_STATUS: rd_mux = {22'h0, state_ff, flash_pwr_ff, standby_ff, strap, exec_ff};
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      dat_ff <= '0;
    end
    else if (ce_i)
    begin
      ack_ff <= wb_req;
      if (wb_req && !wb_we_i)
        dat_ff <= rd_mux;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign exec_enable_o = exec_ff;
  assign regulator_standby_o = standby_ff;
  assign flash_power_o = flash_pwr_ff;
  assign brown_out_reset_o = brown_rst_ff;
  assign irq_o = irq_ff;

endmodule : rps_sequencer

//--- tb/rps_chk.sv
// port-level assertions for the power sequencer
// assumes one clk_i domain, bound into every rps_sequencer
`timescale 1ns/1ns
module rps_chk
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic sleep_req_i,
  input wire logic wake_req_i,
  input wire logic exec_enable_o,
  input wire logic regulator_standby_o,
  input wire logic flash_power_o,
  input wire logic brown_out_reset_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("ack missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  boot_hold_a: assert property ($fell(rst_i) |-> !exec_enable_o [*8])
    else $error("exec early after reset");
  sleep_gate_a: assert property (exec_enable_o && sleep_req_i && ce_i |=> !exec_enable_o)
    else $error("sleep ignored");
  standby_off_a: assert property (regulator_standby_o |-> !flash_power_o && !exec_enable_o)
    else $error("standby while running");
  flash_gate_a: assert property (!flash_power_o |-> !exec_enable_o)
    else $error("exec without flash");
  // ST is at least 8 in every bench, so eight low cycles are always owed
  wake_wait_a: assert property (regulator_standby_o && wake_req_i && ce_i |=> !exec_enable_o [*8])
    else $error("wake skipped settle");
  brown_hold_a: assert property (brown_out_reset_o |-> !exec_enable_o)
    else $error("exec during brown-out");
endmodule : rps_chk

bind rps_sequencer rps_chk i_rps_chk (.*);

//--- tb/testbench.sv
// self-checking bench for rps_sequencer with short delay counts
// assumes rps_regs.svh, rps_pkg and the bound rps_chk
`timescale 1ns/1ns
`include "rps_regs.svh"
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin n_errors++; \
  $display("Error %s exp %0h got %0h", nm, e, a); end end
module testbench;
  import rps_pkg::*;
  localparam int ST = 20;
  localparam int PW = 200;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic ce_i = 1'h1;
  logic regulator_enable_strap_i = 1'h1;
  logic low_voltage_cmp_i = 1'h0;
  logic brown_out_cmp_i = 1'h0;
  logic sleep_req_i = 1'h0;
  logic wake_req_i = 1'h0;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'h0;
  rps_word_t wb_dat_i = 32'h0;
  rps_word_t wb_dat_o;
  rps_word_t rd;
  logic wb_ack_o, exec_enable_o, regulator_standby_o, flash_power_o, brown_out_reset_o, irq_o;
  int n_errors = 0;
  int checks = 0;
  int n;

  rps_sequencer #(.POWER_UP_CYCLES(PW), .SETTLE_CYCLES(ST)) i_rps_sequencer (.*);

  always #10 clk_i = ~clk_i;

  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input rps_word_t d);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    // ack is registered: it is seen at the edge after the one that takes the request
    do @(posedge clk_i); while (wb_ack_o !== 1'h1 && ++k < 20);
    if (k >= 20) n_errors++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk_i);
  endtask : bus

  task automatic rchk(input logic [7:0] a, input rps_word_t e);
    bus(1'h0, a, 4'hF, 32'h0);
    @(negedge clk_i);
    `CHK("read", e, rd)
  endtask : rchk

  task automatic wx(input int lo, input int hi);
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (exec_enable_o !== 1'h1 && n < 5000);
    `CHK("delay", 1'h1, n >= lo && n <= hi)
  endtask : wx

  task automatic t_boot(input logic s, input int lo, input int hi);
    @(posedge clk_i);
    regulator_enable_strap_i <= s;
    rst_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    wx(lo, hi);
    rchk(`RPS_ADR_STATUS, {22'h0, 6'h04, 1'h1, 1'h0, s, 1'h1});
    rchk(`RPS_ADR_RESET_CTRL, 32'h0);
    rchk(`RPS_ADR_INT_FLAG, 32'h1);
  endtask : t_boot

  task automatic nap(input int lo, input int hi, input logic sb, input logic fp);
    @(posedge clk_i);
    sleep_req_i <= 1'h1;
    @(posedge clk_i);
    sleep_req_i <= 1'h0;
    @(negedge clk_i);
    `CHK("exec", 1'h0, exec_enable_o)
    `CHK("standby", sb, regulator_standby_o)
    `CHK("flash", fp, flash_power_o)
    @(posedge clk_i);
    wake_req_i <= 1'h1;
    @(posedge clk_i);
    wake_req_i <= 1'h0;
    wx(lo, hi);
    `CHK("standby", 1'h0, regulator_standby_o)
  endtask : nap

  task automatic t_keep;
    bus(1'h1, `RPS_ADR_RESET_CTRL, 4'h2, 32'h100);
    // byte lane 0 alone must leave the keep bit alone
    bus(1'h1, `RPS_ADR_RESET_CTRL, 4'h1, 32'h0);
    rchk(`RPS_ADR_RESET_CTRL, 32'h100);
    nap(1, 3, 1'h0, 1'h1);
    bus(1'h1, `RPS_ADR_RESET_CTRL, 4'hF, 32'h0);
  endtask : t_keep

  task automatic lvp;
    repeat (4) @(posedge clk_i);
    low_voltage_cmp_i <= 1'h1;
    repeat (6) @(posedge clk_i);
    low_voltage_cmp_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
  endtask : lvp

  task automatic t_lv;
    // the keep-powered wake just before left the ready event pending
    rchk(`RPS_ADR_INT_FLAG, 32'h1);
    bus(1'h1, `RPS_ADR_INT_MASK, 4'hF, 32'hFFFFFFFF);
    rchk(`RPS_ADR_INT_MASK, 32'h103);
    lvp();
    `CHK("irq", 1'h1, irq_o)
    rchk(`RPS_ADR_INT_FLAG, 32'h100);
    `CHK("irq", 1'h0, irq_o)
    bus(1'h1, `RPS_ADR_INT_MASK, 4'hF, 32'h0);
    lvp();
    `CHK("irq", 1'h0, irq_o)
    rchk(`RPS_ADR_INT_FLAG, 32'h100);
    @(posedge clk_i);
    regulator_enable_strap_i <= 1'h0;
    lvp();
    rchk(`RPS_ADR_INT_FLAG, 32'h0);
    @(posedge clk_i);
    regulator_enable_strap_i <= 1'h1;
    bus(1'h1, 8'h10, 4'hF, 32'hFFFFFFFF);
    rchk(8'h10, 32'h0);
  endtask : t_lv

  task automatic t_brown;
    @(posedge clk_i);
    brown_out_cmp_i <= 1'h1;
    repeat (6) @(negedge clk_i);
    `CHK("bor", 1'h1, brown_out_reset_o)
    rchk(`RPS_ADR_RESET_CTRL, 32'h2);
    @(posedge clk_i);
    brown_out_cmp_i <= 1'h0;
    wx(ST, ST + 10);
    rchk(`RPS_ADR_INT_FLAG, 32'h3);
    bus(1'h1, `RPS_ADR_RESET_CTRL, 4'h1, 32'h0);
    rchk(`RPS_ADR_RESET_CTRL, 32'h0);
  endtask : t_brown

  // a sleep request while frozen must be lost, not queued
  task automatic t_freeze;
    @(posedge clk_i);
    ce_i <= 1'h0;
    sleep_req_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    sleep_req_i <= 1'h0;
    ce_i <= 1'h1;
    repeat (2) @(negedge clk_i);
    `CHK("frozen", 1'h1, exec_enable_o)
  endtask : t_freeze

  task automatic wrap_up;
    if (n_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    t_boot(1'h1, ST, ST + 8);
    nap(ST, ST + 4, 1'h1, 1'h0);
    t_keep();
    t_freeze();
    t_lv();
    t_brown();
    t_boot(1'h0, PW, PW + 8);
    t_keep();
    nap(ST, ST + 4, 1'h0, 1'h0);
    wrap_up();
  end

  // whole run is a few hundred cycles; this is well past it
  initial
  begin
    #400000;
    n_errors++;
    wrap_up();
  end
endmodule : testbench
